// file: hw/dual_8bit_timer_pair.sv
// Purpose: pair of 8-bit interval timers with shared prescaler and
//          shared toggle flip-flop, configured over apb
// Assumes: apb master holds setup one cycle then access; ref_clk = fc
// Notes:   compare registers are write-only and read back as zero

`timescale 1ns/1ps
`default_nettype none

module dual_8bit_timer_pair (
	// clock and reset
	input  wire logic        ref_clk,
	input  wire logic        rst_b,
	// apb slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output var  logic [31:0] prdata_reg,
	output var  logic        pready_reg,
	output var  logic        pslverr_reg,
	// timer pins and requests
	input  wire logic        external_count_input,
	output var  logic        toggle_output_pin,
	output var  logic        timer0_match_irq,
	output var  logic        timer1_match_irq
);

	// software-visible state
	logic [7:0]  run_reg, mode_reg, tff_ctl_reg;
	logic [7:0]  compare_value_0, compare0_buf_reg, compare_value_1;
	logic        cmp_hold_reg;

	// timer state
	logic [7:0]  up_count_0, up_count_1, uc0_next, uc1_next;
	logic        shared_toggle_ff, toggle_next;

	// bus decode
	logic        setup_phase, access_done, addr_ok, wr_en;
	logic        hit_cmp0, hit_cmp1, hit_run;
	logic        hit_mode, hit_tff, hit_status;
	logic [31:0] read_data, status_word;
	logic [7:0]  wr_byte;

	// clock sources
	logic        tap8, tap32, tap128, tap2048;
	logic        ext_pulse, t0_tick, t1_tick;

	// modes and events
	logic        mode_8bit, mode_16bit, mode_ppg, mode_pwm;
	logic        run0, run1, en0, en1, hit0, hit1, hit16, carry0;
	logic        ppg_end, pwm_end, inv_enable, inv_event, buf_load;
	logic        irq0_event, irq1_event, tff_cmd_wr;
	logic [7:0]  pwm_top;
	logic [15:0] pair_count_inc;
	logic [1:0]  tff_cmd;

	// count value one step on, wrapping through 00
	function automatic logic [7:0] step8(input logic [7:0] count);
		step8 = count + 8'h01;
	endfunction

	// next step lands on compare; 00 lands on overflow
	function automatic logic reaches(input logic [7:0] count,
		input logic [7:0] cmp);
		reaches = (step8(count) == cmp);
	endfunction

	function automatic logic pick4(input logic [1:0] sel,
		input logic s0, input logic s1, input logic s2, input logic s3);
		unique case (sel)
			2'h0: pick4 = s0;
			2'h1: pick4 = s1;
			2'h2: pick4 = s2;
			2'h3: pick4 = s3;
		endcase
	endfunction

	// shared prescaler with fc/4 front end
	prescale_divider i_prescale_divider (
		.ref_clk     (ref_clk),
		.rst_b       (rst_b),
		.run         (run_reg[timer_pair_pkg::RUN_PRE_BIT]),
		.tap8_reg    (tap8),
		.tap32_reg   (tap32),
		.tap128_reg  (tap128),
		.tap2048_reg (tap2048)
	);

	count_edge_sync i_count_edge_sync (
		.ref_clk  (ref_clk),
		.rst_b    (rst_b),
		.level_in (external_count_input),
		.rise_reg (ext_pulse)
	);

	// apb decode; one access cycle, answer prepared during setup
	assign setup_phase = psel && !penable;
	assign access_done = psel && penable && pready_reg;
	assign hit_cmp0    = (paddr == timer_pair_pkg::ADDR_COMPARE_0);
	assign hit_cmp1    = (paddr == timer_pair_pkg::ADDR_COMPARE_1);
	assign hit_run     = (paddr == timer_pair_pkg::ADDR_RUN);
	assign hit_mode    = (paddr == timer_pair_pkg::ADDR_MODE);
	assign hit_tff     = (paddr == timer_pair_pkg::ADDR_TFF);
	assign hit_status  = (paddr == timer_pair_pkg::ADDR_STATUS);
	assign addr_ok     = hit_cmp0 || hit_cmp1 || hit_run || hit_mode
		|| hit_tff || hit_status;
	assign wr_en       = access_done && pwrite && addr_ok;
	assign wr_byte     = pwdata[7:0];

	assign status_word = {15'h0000, shared_toggle_ff, up_count_1,
		up_count_0};

	// compare registers read back as zero
	assign read_data = hit_run ? {24'h00_0000, run_reg}
		: hit_mode ? {24'h00_0000, mode_reg}
		: hit_tff ? {24'h00_0000, tff_ctl_reg}
		: hit_status ? status_word
		: 32'h0000_0000;

	assign mode_8bit  = (mode_reg[timer_pair_pkg::MODE_PAIR_LO +: 2]
		== timer_pair_pkg::PAIR_8BIT);
	assign mode_16bit = (mode_reg[timer_pair_pkg::MODE_PAIR_LO +: 2]
		== timer_pair_pkg::PAIR_16BIT);
	assign mode_ppg   = (mode_reg[timer_pair_pkg::MODE_PAIR_LO +: 2]
		== timer_pair_pkg::PAIR_PPG);
	assign mode_pwm   = (mode_reg[timer_pair_pkg::MODE_PAIR_LO +: 2]
		== timer_pair_pkg::PAIR_PWM);

	assign run0 = run_reg[timer_pair_pkg::RUN_T0_BIT];
	assign run1 = run_reg[timer_pair_pkg::RUN_T1_BIT];

	assign t0_tick = pick4(mode_reg[timer_pair_pkg::MODE_T0CLK_LO +: 2],
		ext_pulse, tap8, tap32, tap128);
	// timer 1 source outside cascade mode
	assign t1_tick = pick4(mode_reg[timer_pair_pkg::MODE_T1CLK_LO +: 2],
		hit0, tap8, tap128, tap2048);

	assign en0 = run0 && t0_tick;
	assign en1 = run1 && t1_tick && !mode_16bit;

	assign hit0    = en0 && reaches(up_count_0, compare_value_0);
	assign hit1    = en1 && reaches(up_count_1, compare_value_1);
	assign ppg_end = en0 && mode_ppg
		&& reaches(up_count_0, compare_value_1);

	assign pwm_top = (mode_reg[timer_pair_pkg::MODE_PWMW_LO +: 2]
		== timer_pair_pkg::PWMW_6) ? timer_pair_pkg::PWM_TOP_6
		: (mode_reg[timer_pair_pkg::MODE_PWMW_LO +: 2]
		== timer_pair_pkg::PWMW_7) ? timer_pair_pkg::PWM_TOP_7
		: timer_pair_pkg::PWM_TOP_8;
	assign pwm_end = en0 && mode_pwm && (step8(up_count_0) == pwm_top);

	// cascade: both halves must match together
	assign pair_count_inc = {up_count_1, up_count_0} + 16'h0001;
	assign carry0 = en0 && (up_count_0 == 8'hFF);
	assign hit16  = en0 && mode_16bit && run1 && !cmp_hold_reg
		&& (pair_count_inc == {compare_value_1, compare_value_0});

	assign irq0_event = (mode_8bit || mode_ppg) ? (hit0 || ppg_end)
		: mode_pwm ? pwm_end : 1'b0;
	assign irq1_event = mode_16bit ? hit16 : mode_ppg ? 1'b0 : hit1;

	// inversion source follows the active mode
	assign inv_enable = tff_ctl_reg[timer_pair_pkg::TFF_INV_BIT];
	assign inv_event  = mode_16bit ? hit16
		: mode_ppg ? (hit0 || ppg_end)
		: mode_pwm ? (hit0 || pwm_end)
		: tff_ctl_reg[timer_pair_pkg::TFF_SRC_BIT] ? hit1 : hit0;

	// buffer transfer only in pulse modes
	assign buf_load = tff_ctl_reg[timer_pair_pkg::TFF_DOUBLE_BUFFER_ENABLE_BIT]
		&& ((mode_ppg && ppg_end) || (mode_pwm && pwm_end));

	assign tff_cmd    = wr_byte[timer_pair_pkg::TFF_CMD_LO +: 2];
	assign tff_cmd_wr = wr_en && hit_tff
		&& (tff_cmd != timer_pair_pkg::TFF_CMD_NONE);

	// counter next values
	always_comb
	begin
		uc0_next = up_count_0;
		uc1_next = up_count_1;
		if (!run0)
			uc0_next = 8'h00;
		else if (mode_16bit)
			uc0_next = hit16 ? 8'h00 : en0 ? step8(up_count_0) : up_count_0;
		// cycle ends on compare 1, compare 0 toggles and requests without clearing
		else if (mode_ppg)
			uc0_next = ppg_end ? 8'h00
				: en0 ? step8(up_count_0) : up_count_0;
		// overflow of 2^n-1 clears the count
		else if (mode_pwm)
			uc0_next = pwm_end ? 8'h00
				: en0 ? step8(up_count_0) : up_count_0;
		else
			uc0_next = hit0 ? 8'h00 : en0 ? step8(up_count_0) : up_count_0;

		if (!run1)
			uc1_next = 8'h00;
		else if (mode_16bit)
			uc1_next = hit16 ? 8'h00
				: carry0 ? step8(up_count_1) : up_count_1;
		else
			uc1_next = hit1 ? 8'h00 : en1 ? step8(up_count_1) : up_count_1;
	end

	// toggle next value; a software command overrides a timer event
	always_comb
	begin
		toggle_next = shared_toggle_ff;
		if (tff_cmd_wr)
		begin
			unique case (tff_cmd)
				timer_pair_pkg::TFF_CMD_INVERT: toggle_next = !shared_toggle_ff;
				timer_pair_pkg::TFF_CMD_SET:    toggle_next = 1'b1;
				timer_pair_pkg::TFF_CMD_CLEAR:  toggle_next = 1'b0;
				default:                        toggle_next = shared_toggle_ff;
			endcase
		end
		else if (inv_enable && inv_event)
			toggle_next = !shared_toggle_ff;
	end

	// apb answer registers
	always_ff @(posedge ref_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			pready_reg  <= 1'b0;
			pslverr_reg <= 1'b0;
			prdata_reg  <= 32'h0000_0000;
		end
		else
		begin
			pready_reg  <= setup_phase;
			pslverr_reg <= setup_phase && !addr_ok;
			prdata_reg  <= (setup_phase && !pwrite) ? read_data
				: 32'h0000_0000;
		end
	end

	// control registers
	always_ff @(posedge ref_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			run_reg     <= timer_pair_pkg::RUN_RESET;
			mode_reg    <= timer_pair_pkg::MODE_RESET;
			tff_ctl_reg <= timer_pair_pkg::TFF_RESET;
		end
		else
		begin
			if (wr_en && hit_run)
				run_reg <= wr_byte;
			if (wr_en && hit_mode)
				mode_reg <= wr_byte;
			// command bits are actions and read back as no-op
			if (wr_en && hit_tff)
				tff_ctl_reg <= {wr_byte[7:4], timer_pair_pkg::TFF_CMD_NONE,
					wr_byte[1:0]};
		end
	end

	// compare registers; reset clears them to 00 before first write
	always_ff @(posedge ref_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			compare_value_0  <= 8'h00;
			compare0_buf_reg <= 8'h00;
			compare_value_1  <= 8'h00;
			cmp_hold_reg     <= 1'b0;
		end
		else
		begin
			// shared address, buffered write hits buffer only
			if (wr_en && hit_cmp0)
			begin
				compare0_buf_reg <= wr_byte;
				if (!tff_ctl_reg[timer_pair_pkg::TFF_DOUBLE_BUFFER_ENABLE_BIT])
					compare_value_0 <= wr_byte;
			end
			else if (buf_load)
				compare_value_0 <= compare0_buf_reg;
			if (wr_en && hit_cmp1)
				compare_value_1 <= wr_byte;
			// cascade compare waits for the upper half after a low write
			if (wr_en && hit_cmp1)
				cmp_hold_reg <= 1'b0;
			else if (wr_en && hit_cmp0)
				cmp_hold_reg <= 1'b1;
		end
	end

	// timer state and outputs
	always_ff @(posedge ref_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			up_count_0        <= 8'h00;
			up_count_1        <= 8'h00;
			shared_toggle_ff  <= 1'b0;
			toggle_output_pin <= 1'b0;
			timer0_match_irq  <= 1'b0;
			timer1_match_irq  <= 1'b0;
		end
		else
		begin
			up_count_0        <= uc0_next;
			up_count_1        <= uc1_next;
			shared_toggle_ff  <= toggle_next;
			toggle_output_pin <= toggle_next;
			timer0_match_irq  <= irq0_event;
			timer1_match_irq  <= irq1_event;
		end
	end

endmodule

`default_nettype wire

// file: hw/timer_pair_pkg.sv
// Purpose: shared constants for the dual 8-bit timer pair
// Assumes: apb byte addresses are four times the register index
// Notes:   field positions, codes and reset values live here; the checks, the bench and the compare resets repeat some as literals

`default_nettype none

package timer_pair_pkg;

	// bus geometry
	localparam int unsigned ADDR_W = 8;
	localparam int unsigned DATA_W = 32;

	// register indices; byte address is index times four
	localparam logic [5:0] IDX_COMPARE_0 = 6'h22;
	localparam logic [5:0] IDX_COMPARE_1 = 6'h23;
	localparam logic [5:0] IDX_RUN       = 6'h20;
	localparam logic [5:0] IDX_MODE      = 6'h24;
	localparam logic [5:0] IDX_TFF       = 6'h25;
	localparam logic [5:0] IDX_STATUS    = 6'h27;

	localparam logic [7:0] ADDR_COMPARE_0 = {IDX_COMPARE_0, 2'b00};
	localparam logic [7:0] ADDR_COMPARE_1 = {IDX_COMPARE_1, 2'b00};
	localparam logic [7:0] ADDR_RUN       = {IDX_RUN, 2'b00};
	localparam logic [7:0] ADDR_MODE      = {IDX_MODE, 2'b00};
	localparam logic [7:0] ADDR_TFF       = {IDX_TFF, 2'b00};
	localparam logic [7:0] ADDR_STATUS    = {IDX_STATUS, 2'b00};

	// timer_run_control fields
	localparam int unsigned RUN_T0_BIT  = 0;
	localparam int unsigned RUN_T1_BIT  = 1;
	localparam int unsigned RUN_PRE_BIT = 7;
	localparam logic [7:0]  RUN_RESET   = 8'h00;

	// timer_mode_control fields
	localparam int unsigned MODE_T0CLK_LO = 0;
	localparam int unsigned MODE_T1CLK_LO = 2;
	localparam int unsigned MODE_PWMW_LO  = 4;
	localparam int unsigned MODE_PAIR_LO  = 6;
	localparam logic [7:0]  MODE_RESET    = 8'h00;

	// pair_mode_field codes
	localparam logic [1:0] PAIR_8BIT  = 2'h0;
	localparam logic [1:0] PAIR_16BIT = 2'h1;
	localparam logic [1:0] PAIR_PPG   = 2'h2;
	localparam logic [1:0] PAIR_PWM   = 2'h3;

	// pwm_width_select codes and the matching 2^n-1 tops
	localparam logic [1:0] PWMW_6    = 2'h1;
	localparam logic [1:0] PWMW_7    = 2'h2;
	localparam logic [7:0] PWM_TOP_6 = 8'h3F;
	localparam logic [7:0] PWM_TOP_7 = 8'h7F;
	localparam logic [7:0] PWM_TOP_8 = 8'hFF;

	// toggle_ff_control fields
	localparam int unsigned TFF_SRC_BIT  = 0;
	localparam int unsigned TFF_INV_BIT  = 1;
	localparam int unsigned TFF_CMD_LO   = 2;
	localparam int unsigned TFF_DOUBLE_BUFFER_ENABLE_BIT = 7;
	localparam logic [7:0]  TFF_RESET    = 8'h0C;

	// toggle_ff_command codes
	localparam logic [1:0] TFF_CMD_INVERT = 2'h0;
	localparam logic [1:0] TFF_CMD_SET    = 2'h1;
	localparam logic [1:0] TFF_CMD_CLEAR  = 2'h2;
	localparam logic [1:0] TFF_CMD_NONE   = 2'h3;

	// prescaler: fc/4 feeds 9 bits; taps are all-ones spans of low bits
	localparam int unsigned PRE_W        = 9;
	localparam logic [1:0]  FC_DIV_LAST  = 2'h3;
	localparam logic [8:0]  TAP8_MASK    = 9'h001;
	localparam logic [8:0]  TAP32_MASK   = 9'h007;
	localparam logic [8:0]  TAP128_MASK  = 9'h01F;
	localparam logic [8:0]  TAP2048_MASK = 9'h1FF;

endpackage

`default_nettype wire

// file: hw/prescale_divider.sv
// Purpose: fc/4 divider and 9-bit prescaler giving single-cycle taps
// Assumes: ref_clk is the system clock fc
// Notes:   taps are registered so counters see clean one-cycle enables

`timescale 1ns/1ps
`default_nettype none

module prescale_divider (
	// clock and reset
	input  wire logic ref_clk,
	input  wire logic rst_b,
	// control
	input  wire logic run,
	// tap pulses
	output var  logic tap8_reg,
	output var  logic tap32_reg,
	output var  logic tap128_reg,
	output var  logic tap2048_reg
);

	logic [1:0]                         div_reg;
	logic [timer_pair_pkg::PRE_W-1:0]   pre_reg;
	logic                               quarter;

	function automatic logic span_full(input logic [8:0] v,
		input logic [8:0] mask);
		span_full = ((v & mask) == mask);
	endfunction

	assign quarter = run && (div_reg == timer_pair_pkg::FC_DIV_LAST);

	always_ff @(posedge ref_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			div_reg     <= 2'h0;
			pre_reg     <= 9'h000;
			tap8_reg    <= 1'b0;
			tap32_reg   <= 1'b0;
			tap128_reg  <= 1'b0;
			tap2048_reg <= 1'b0;
		end
		else
		begin
			// halted and cleared while not running
			div_reg     <= run ? div_reg + 2'h1 : 2'h0;
			pre_reg     <= !run ? 9'h000 : quarter ? pre_reg + 9'h001 : pre_reg;
			// taps at 8, 32, 128, 2048 fc
			tap8_reg    <= quarter && span_full(pre_reg,
				timer_pair_pkg::TAP8_MASK);
			tap32_reg   <= quarter && span_full(pre_reg,
				timer_pair_pkg::TAP32_MASK);
			tap128_reg  <= quarter && span_full(pre_reg,
				timer_pair_pkg::TAP128_MASK);
			tap2048_reg <= quarter && span_full(pre_reg,
				timer_pair_pkg::TAP2048_MASK);
		end
	end

endmodule

`default_nettype wire

// file: hw/count_edge_sync.sv
// Purpose: bring the external count input into ref_clk as a pulse
// Assumes: input pulses stay high and low for at least two clocks
// Notes:   first stage is read only by the second stage

`timescale 1ns/1ps
`default_nettype none

module count_edge_sync (
	// clock and reset
	input  wire logic ref_clk,
	input  wire logic rst_b,
	// raw input and rising-edge pulse
	input  wire logic level_in,
	output var  logic rise_reg
);

	logic meta_reg;
	logic sync_reg;
	logic prev_reg;

	always_ff @(posedge ref_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			meta_reg <= 1'b0;
			sync_reg <= 1'b0;
			prev_reg <= 1'b0;
			rise_reg <= 1'b0;
		end
		else
		begin
			meta_reg <= level_in;
			sync_reg <= meta_reg;
			prev_reg <= sync_reg;
			rise_reg <= sync_reg && !prev_reg;
		end
	end

endmodule

`default_nettype wire

// file: dv/timer_pair_props.sv
// Purpose: port-level timing checks for the timer pair
// Assumes: one clock domain; apb master as driven by the bench
// Notes:   run and mode shadows are rebuilt from observed writes

`timescale 1ns/1ps
`default_nettype none

module timer_pair_props (
	// clock and reset
	input wire logic        ref_clk,
	input wire logic        rst_b,
	// apb
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [7:0]  paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata_reg,
	input wire logic        pready_reg,
	input wire logic        pslverr_reg,
	// timer pins
	input wire logic        external_count_input,
	input wire logic        toggle_output_pin,
	input wire logic        timer0_match_irq,
	input wire logic        timer1_match_irq
);
	logic [7:0] run_sh_reg;
	logic [7:0] mode_sh_reg;
	logic [2:0] stop_cnt_reg;
	wire        wr_acc;
	wire        wr_tff;
	assign wr_acc = psel && penable && pwrite && pready_reg;
	assign wr_tff = wr_acc && paddr == timer_pair_pkg::ADDR_TFF;

	// stop_cnt saturates: irq outputs are registered, so allow slack
	always_ff @(posedge ref_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			run_sh_reg   <= 8'h00;
			mode_sh_reg  <= 8'h00;
			stop_cnt_reg <= 3'h0;
		end
		else
		begin
			if (wr_acc && paddr == timer_pair_pkg::ADDR_RUN)
				run_sh_reg <= pwdata[7:0];
			if (wr_acc && paddr == timer_pair_pkg::ADDR_MODE)
				mode_sh_reg <= pwdata[7:0];
			if (run_sh_reg[1:0] != 2'b00)
				stop_cnt_reg <= 3'h0;
			else if (stop_cnt_reg != 3'h7)
				stop_cnt_reg <= stop_cnt_reg + 3'h1;
		end
	end

	default clocking @(posedge ref_clk);
	endclocking
	default disable iff (!rst_b);

	ready_after_setup_a:
		assert property (psel && !penable |=> pready_reg)
		else $error("pready missing after setup");
	ready_single_a:
		assert property (pready_reg |=> !pready_reg)
		else $error("pready longer than one cycle");
	idle_data_zero_a:
		assert property (!pready_reg |-> prdata_reg == 32'h0000_0000)
		else $error("read data outside access");
	compare_read_zero_a:
		assert property (pready_reg && !pwrite
			&& (paddr == timer_pair_pkg::ADDR_COMPARE_0
			|| paddr == timer_pair_pkg::ADDR_COMPARE_1)
			|-> prdata_reg == 32'h0000_0000)
		else $error("compare register read back");
	irq0_single_a:
		assert property (timer0_match_irq |=> !timer0_match_irq)
		else $error("timer 0 request not a pulse");
	irq1_single_a:
		assert property (timer1_match_irq |=> !timer1_match_irq)
		else $error("timer 1 request not a pulse");
	err_with_ready_a:
		assert property (pslverr_reg |-> pready_reg)
		else $error("slave error outside access");
	toggle_cause_a:
		assert property ($changed(toggle_output_pin) |-> timer0_match_irq
			|| timer1_match_irq || $past(wr_tff) || $past(wr_tff, 2)
			|| mode_sh_reg[7:6] == timer_pair_pkg::PAIR_PWM)
		else $error("toggle changed without a cause");
	stop_quiet_a:
		assert property (stop_cnt_reg == 3'h7
			|-> !timer0_match_irq && !timer1_match_irq)
		else $error("request while both timers stopped");
	tff_set_a:
		assert property (wr_tff && pwdata[3:2] == timer_pair_pkg::TFF_CMD_SET
			|-> ##[1:2] toggle_output_pin)
		else $error("set command did not set toggle");
	tff_clear_a:
		assert property (wr_tff
			&& pwdata[3:2] == timer_pair_pkg::TFF_CMD_CLEAR
			|-> ##[1:2] !toggle_output_pin)
		else $error("clear command did not clear toggle");
endmodule

bind dual_8bit_timer_pair timer_pair_props i_timer_pair_props (
	.ref_clk, .rst_b, .psel, .penable, .pwrite, .paddr, .pwdata,
	.prdata_reg, .pready_reg, .pslverr_reg, .external_count_input,
	.toggle_output_pin, .timer0_match_irq, .timer1_match_irq
);

`default_nettype wire

// file: dv/dual_8bit_timer_pair_tb.sv
// Purpose: directed register-level test of the timer pair
// Assumes: apb slave; ref_clk 100 MHz; cycle counts are ints
// Notes:   periods are clocks between successive one-cycle events

`timescale 1ns/1ps
`default_nettype none

module dual_8bit_timer_pair_tb;
	logic        ref_clk;
	logic        rst_b;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [7:0]  paddr;
	logic [31:0] pwdata;
	logic        ext_in;
	wire  [31:0] prdata_reg;
	wire         pready_reg;
	wire         pslverr_reg;
	wire         tog;
	wire         irq0;
	wire         irq1;
	int          bad_count = 0;
	int          check_count = 0;
	int          i0c = 0;
	int          n;
	int          m;
	logic [31:0] rd;
	logic        er;
	logic [1:0]  t0c [4] = '{2'h1, 2'h1, 2'h2, 2'h3};
	int          p0 [4] = '{24, 24, 96, 384};
	int          p1 [4] = '{48, 16, 256, 4096};
	int          pp [3] = '{504, 1016, 2040};
	logic [1:0]  pw [3];

	dual_8bit_timer_pair i_dual_8bit_timer_pair (
		.ref_clk(ref_clk), .rst_b(rst_b), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata_reg(prdata_reg),
		.pready_reg(pready_reg), .pslverr_reg(pslverr_reg),
		.external_count_input(ext_in), .toggle_output_pin(tog),
		.timer0_match_irq(irq0), .timer1_match_irq(irq1)
	);

	initial
	begin
		ref_clk = 1'b0;
		forever #5 ref_clk = ~ref_clk;
	end

	always @(posedge ref_clk)
	begin
		if (irq0 === 1'b1)
			i0c <= i0c + 1;
	end

	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp)
		begin
			bad_count++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic hang();
		bad_count++;
		report_and_stop();
	endtask

	// request held until pready is seen high at a rising edge
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		int k;
		@(posedge ref_clk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge ref_clk);
		penable <= 1'b1;
		k = 0;
		do
		begin
			@(posedge ref_clk);
			k++;
		end
		while (pready_reg !== 1'b1 && k < 50);
		if (k >= 50)
			hang();
		rd = prdata_reg;
		er = pslverr_reg;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		apb(1'b1, a, {24'h00_0000, d});
	endtask

	task automatic rchk(input logic [7:0] a, input logic [7:0] e);
		apb(1'b0, a, 32'h0000_0000);
		chk(rd, {24'h00_0000, e});
	endtask

	// s: 0 timer 0 request, 1 timer 1 request, 2 toggle change
	task automatic ev(input int s, output int c);
		logic t;
		t = tog;
		c = 0;
		do
		begin
			@(posedge ref_clk);
			#1;
			c++;
		end
		while (!(s == 0 ? irq0 === 1'b1 : s == 1 ? irq1 === 1'b1
			: tog !== t) && c < 6000);
		if (c >= 6000)
			hang();
	endtask

	initial
	begin
		rst_b   = 1'b0;
		psel    = 1'b0;
		penable = 1'b0;
		pwrite  = 1'b0;
		paddr   = 8'h00;
		pwdata  = 32'h0000_0000;
		ext_in  = 1'b0;
		pw[0]   = timer_pair_pkg::PWMW_6;
		pw[1]   = timer_pair_pkg::PWMW_7;
		pw[2]   = 2'h0;
		repeat (20) @(posedge ref_clk);
		rst_b <= 1'b1;
		rchk(timer_pair_pkg::ADDR_RUN, timer_pair_pkg::RUN_RESET);
		rchk(timer_pair_pkg::ADDR_MODE, timer_pair_pkg::MODE_RESET);
		rchk(timer_pair_pkg::ADDR_TFF, timer_pair_pkg::TFF_RESET);
		rchk(timer_pair_pkg::ADDR_STATUS, 8'h00);
		wr(timer_pair_pkg::ADDR_COMPARE_0, 8'h55);
		rchk(timer_pair_pkg::ADDR_COMPARE_0, 8'h00);
		rchk(timer_pair_pkg::ADDR_COMPARE_1, 8'h00);
		apb(1'b0, 8'h84, 32'h0000_0000);
		chk(32'(er), 32'h0000_0001);
		$display("test reset done");
		// set, invert, invert, clear
		for (int i = 0; i < 4; i++)
		begin
			m = (i == 0) ? 1 : (i == 3) ? 2 : 0;
			wr(timer_pair_pkg::ADDR_TFF, {4'h0, m[1:0], 2'h0});
			repeat (2) @(posedge ref_clk);
			#1;
			chk(32'(tog), 32'(i == 0 || i == 2));
		end
		$display("test toggle commands done");
		wr(timer_pair_pkg::ADDR_MODE, 8'h05);
		wr(timer_pair_pkg::ADDR_COMPARE_0, 8'h03);
		wr(timer_pair_pkg::ADDR_COMPARE_1, 8'h00);
		wr(timer_pair_pkg::ADDR_TFF, 8'h0E);
		wr(timer_pair_pkg::ADDR_RUN, 8'h83);
		ev(0, n);
		ev(0, n);
		chk(n, 24);
		ev(2, n);
		chk(n, 24);
		ev(1, n);
		ev(1, n);
		chk(n, 2048);
		wr(timer_pair_pkg::ADDR_TFF, 8'h0F);
		ev(2, n);
		ev(2, n);
		chk(n, 2048);
		wr(timer_pair_pkg::ADDR_RUN, 8'h00);
		wr(timer_pair_pkg::ADDR_COMPARE_1, 8'h02);
		wr(timer_pair_pkg::ADDR_RUN, 8'h83);
		for (int i = 0; i < 4; i++)
		begin
			wr(timer_pair_pkg::ADDR_MODE, {4'h0, i[1:0], t0c[i]});
			ev(0, n);
			ev(0, n);
			chk(n, p0[i]);
			ev(1, n);
			ev(1, n);
			chk(n, p1[i]);
		end
		$display("test interval done");
		wr(timer_pair_pkg::ADDR_RUN, 8'h03);
		repeat (4) @(posedge ref_clk);
		m = i0c;
		repeat (200) @(posedge ref_clk);
		chk(i0c - m, 0);
		wr(timer_pair_pkg::ADDR_RUN, 8'h00);
		apb(1'b0, timer_pair_pkg::ADDR_STATUS, 32'h0000_0000);
		chk({16'h0000, rd[15:0]}, 32'h0000_0000);
		wr(timer_pair_pkg::ADDR_MODE, 8'h00);
		wr(timer_pair_pkg::ADDR_COMPARE_0, 8'h02);
		wr(timer_pair_pkg::ADDR_RUN, 8'h01);
		m = i0c;
		@(posedge ref_clk);
		repeat (6)
		begin
			ext_in <= 1'b1;
			repeat (4) @(posedge ref_clk);
			ext_in <= 1'b0;
			repeat (4) @(posedge ref_clk);
		end
		repeat (8) @(posedge ref_clk);
		chk(i0c - m, 3);
		$display("test prescaler and external done");
		wr(timer_pair_pkg::ADDR_RUN, 8'h00);
		wr(timer_pair_pkg::ADDR_MODE, {timer_pair_pkg::PAIR_16BIT, 6'h01});
		wr(timer_pair_pkg::ADDR_COMPARE_0, 8'h02);
		wr(timer_pair_pkg::ADDR_COMPARE_1, 8'h01);
		wr(timer_pair_pkg::ADDR_RUN, 8'h83);
		ev(1, n);
		ev(1, n);
		chk(n, 2064);
		ev(2, n);
		chk(n, 2064);
		wr(timer_pair_pkg::ADDR_COMPARE_0, 8'h02);
		repeat (2100) @(posedge ref_clk);
		apb(1'b0, timer_pair_pkg::ADDR_STATUS, 32'h0000_0000);
		chk(32'(rd[15:0] > 16'h0102), 32'h0000_0001);
		$display("test cascade done");
		wr(timer_pair_pkg::ADDR_RUN, 8'h00);
		wr(timer_pair_pkg::ADDR_COMPARE_0, 8'h10);
		wr(timer_pair_pkg::ADDR_RUN, 8'h81);
		for (int j = 0; j < 3; j++)
		begin
			wr(timer_pair_pkg::ADDR_MODE,
				{timer_pair_pkg::PAIR_PWM, pw[j], 4'h1});
			ev(0, n);
			ev(0, n);
			chk(n, pp[j]);
		end
		wr(timer_pair_pkg::ADDR_MODE, {timer_pair_pkg::PAIR_PWM, pw[0], 4'h1});
		ev(0, n);
		ev(0, n);
		ev(2, n);
		chk(n, 128);
		ev(0, n);
		wr(timer_pair_pkg::ADDR_TFF, 8'h8E);
		wr(timer_pair_pkg::ADDR_COMPARE_0, 8'h20);
		ev(2, n);
		chk(32'(n < 128), 32'h0000_0001);
		ev(0, n);
		ev(2, n);
		chk(n, 256);
		$display("test pwm done");
		wr(timer_pair_pkg::ADDR_RUN, 8'h00);
		wr(timer_pair_pkg::ADDR_TFF, 8'h0E);
		wr(timer_pair_pkg::ADDR_MODE, {timer_pair_pkg::PAIR_PPG, 6'h01});
		wr(timer_pair_pkg::ADDR_COMPARE_0, 8'h04);
		wr(timer_pair_pkg::ADDR_COMPARE_1, 8'h0A);
		wr(timer_pair_pkg::ADDR_RUN, 8'h83);
		ev(0, n);
		ev(0, n);
		ev(0, m);
		chk(n + m, 80);
		chk(n * m, 1536);
		wr(timer_pair_pkg::ADDR_RUN, 8'h00);
		repeat (20) @(posedge ref_clk);
		$display("test ppg done");
		report_and_stop();
	end
endmodule

`default_nettype wire
